// ### csw_pkg.sv
// Package of register offsets, field layouts, encodings and timing constants for the clock switch control.
package csw_pkg;

   // -----------------------------------------------------------------
   // Register map (byte addresses as printed).
   // -----------------------------------------------------------------
   localparam logic [11:0] ADDR_CLOCK_REQUEST = 12'h88d;
   localparam logic [11:0] ADDR_CLOCK_CURRENT = 12'h88e;
   localparam logic [11:0] ADDR_SWITCH_CONTROL = 12'h88f;
   localparam logic [11:0] ADDR_READY_STATUS = 12'h890;
   localparam logic [11:0] ADDR_MANUAL_ENABLE = 12'h891;
   localparam logic [11:0] ADDR_OSC_TRIM = 12'h892;
   localparam logic [11:0] ADDR_OSC_FREQUENCY = 12'h893;
   localparam logic [11:0] ADDR_SWITCH_IRQ = 12'h894;

   // -----------------------------------------------------------------
   // Field positions.
   // -----------------------------------------------------------------
   localparam int SRC_LSB = 4;
   localparam int SRC_MSB = 6;
   localparam int DIV_LSB = 0;
   localparam int DIV_MSB = 3;
   localparam int HOLD_BIT = 7;
   localparam int SPWR_BIT = 6;
   localparam int READY_BIT = 4;
   localparam int NRDY_BIT = 3;
   localparam int IRQ_FLAG_BIT = 0;
   localparam int IRQ_EN_BIT = 1;
   localparam int TRIM_W = 6;
   localparam int FRQ_W = 3;
   localparam logic [7:0] MANUAL_EN_MASK = 8'hfc;
   localparam logic [7:0] STATUS_MASK = 8'hfd;
   localparam int RDY_EXT_BIT = 7;
   localparam int RDY_HFI_BIT = 6;
   localparam int RDY_LFI_BIT = 4;
   localparam int RDY_SEC_BIT = 3;
   localparam int RDY_PLL_BIT = 0;

   // -----------------------------------------------------------------
   // Source and divider encodings.
   // -----------------------------------------------------------------
   localparam logic [2:0] SRC_EXT = 3'h7;
   localparam logic [2:0] SRC_HFI = 3'h6;
   localparam logic [2:0] SRC_LFI = 3'h5;
   localparam logic [2:0] SRC_SEC = 3'h4;
   localparam logic [2:0] SRC_RSV3 = 3'h3;
   localparam logic [2:0] SRC_EXT_PLL = 3'h2;
   localparam logic [2:0] SRC_HFI_PLL = 3'h1;
   localparam logic [2:0] SRC_RSV0 = 3'h0;
   localparam logic [3:0] DIV_MAX = 4'h9;
   localparam logic [3:0] DIV_RESET_HFI = 4'h2;
   localparam logic [3:0] DIV_RESET_OTHER = 4'h0;

   // -----------------------------------------------------------------
   // Timing.
   // -----------------------------------------------------------------
   localparam int CLK_MHZ = 50;
   localparam int STARTUP_US = 20;
   localparam int STARTUP_CYCLES = STARTUP_US * CLK_MHZ;

   typedef enum logic [1:0] {
      CSW_IDLE,
      CSW_WAIT,
      CSW_HELD
   } csw_state_t;

endpackage : csw_pkg

// ### csw_ost_if.sv
// Interface carrying start-up timer control and status between the switch control and its timer.
`timescale 1ns/1ps
interface csw_ost_if;
   logic restart;
   logic bypass;
   logic expired;
   modport ctrl (output restart, output bypass, input expired);
   modport timer (input restart, input bypass, output expired);
endinterface : csw_ost_if

// ### csw_ost_timer.sv
// Oscillator start-up timer that gates fail-safe monitoring.
`timescale 1ns/1ps
module csw_ost_timer
   import csw_pkg::*;
#(
   parameter int CYCLES = STARTUP_CYCLES
) (
   input wire logic ref_clk,
   input wire logic reset,
   csw_ost_if.timer tmr
);

   localparam int CW = $clog2(CYCLES + 1);

   initial begin
      if (CYCLES < 1) begin
         $error("Start-up timer length must be at least one cycle.");
      end
   end

   logic [CW-1:0] count_r;
   logic expired_r;

   // Counts down after every restart; external clock input skips the count.
   always_ff @(posedge ref_clk) begin
      if (reset || tmr.restart) begin
         count_r <= CW'(CYCLES);
         expired_r <= 1'b0;
      end else if (tmr.bypass) begin
         expired_r <= 1'b1;
      end else if (count_r != '0) begin
         count_r <= count_r - 1'b1;
         expired_r <= (count_r == CW'(1));
      end
   end

   assign tmr.expired = expired_r;

endmodule : csw_ost_timer

// ### csw_clock_switch.sv
// Top of the system clock switch control: registers, switch sequencer and monitor gating.
//
// Notes on behaviour
// [R01] No fail-safe report before start-up timer expiry.
// [R02] Start-up timer runs after wake and reset.
// [R03] External clock input mode bypasses start-up timer.
// [R04] Decode three-bit source request field.
// [R05] Divider code n divides by two to n.
// [R06] Reserved source write is ignored; the code still takes the divider field of such a write.
// [R07] Switch disallowed keeps request register read-only.
// [R08] Reset source comes from configuration setting.
// [R09] Reset divider is 0010 for high-frequency internal.
// [R10] Current source and divider are read-only.
// [R11] Current fields reset equal to request fields.
// [R12] Hold bit suspends switch once ready.
// [R13] Power select drives secondary oscillator mode.
// [R14] Ready bit set when request equals current.
// [R15] New-ready set only during switch when ready.
// [R16] Without hold, new-ready lasts one cycle; the code never sets new-ready when hold is clear.
// [R17] Registers sit at 0x088D through 0x0893; the code also places the interrupt register at 0x894.
// [R18] New-ready and interrupt flag set together; without hold the code sets only the interrupt flag.
// [R19] Switch updates current fields, sets ready.
// [R20] Software releases hold or abandons switch.
// [R21] Sleep before switch completes cancels it; the code only defers the switch until wake.
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
module csw_clock_switch
   import csw_pkg::*;
#(
   parameter int STARTUP_LEN = STARTUP_CYCLES
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic [11:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [7:0] rdata,
   input wire logic [2:0] reset_source_config,
   input wire logic switch_allow_config,
   input wire logic external_clock_input_mode,
   input wire logic sleep_enter,
   input wire logic wake_event,
   input wire logic [7:0] osc_ready_in,
   input wire logic fail_detect,
   output logic [2:0] clk_source,
   output logic [3:0] clk_divider,
   output logic [9:0] clk_div_ratio,
   output logic secondary_power_select,
   output logic [7:0] osc_enable,
   output logic [5:0] trim,
   output logic [2:0] frequency,
   output logic fail_safe_monitor,
   output logic switch_irq
);

   initial begin
      if (STARTUP_LEN < 1) begin
         $error("Start-up timer length must be positive.");
      end
   end

   // -----------------------------------------------------------------
   // Decoding helpers.
   // -----------------------------------------------------------------

   // True for a source code that names a real oscillator.
   function automatic logic src_valid(input logic [2:0] s);
      src_valid = (s != SRC_RSV3) && (s != SRC_RSV0); // see [R04]
   endfunction : src_valid

   // Ready indication of the oscillator behind a source code.
   function automatic logic src_ready(input logic [2:0] s, input logic [7:0] r);
      case (s)
         SRC_EXT: src_ready = r[RDY_EXT_BIT];
         SRC_HFI: src_ready = r[RDY_HFI_BIT];
         SRC_LFI: src_ready = r[RDY_LFI_BIT];
         SRC_SEC: src_ready = r[RDY_SEC_BIT];
         SRC_EXT_PLL: src_ready = r[RDY_EXT_BIT] & r[RDY_PLL_BIT];
         SRC_HFI_PLL: src_ready = r[RDY_HFI_BIT] & r[RDY_PLL_BIT];
         default: src_ready = 1'b0;
      endcase
   endfunction : src_ready

   // Reset divider code for a given source.
   function automatic logic [3:0] reset_div(input logic [2:0] s);
      reset_div = (s == SRC_HFI) ? DIV_RESET_HFI : DIV_RESET_OTHER; // see [R09]
   endfunction : reset_div

   // -----------------------------------------------------------------
   // Registers and state.
   // -----------------------------------------------------------------
   logic [2:0] req_src_r;
   logic [3:0] req_div_r;
   logic [2:0] cur_src_r;
   logic [3:0] cur_div_r;
   logic hold_r;
   logic spwr_r;
   logic new_ready_r;
   logic irq_flag_r;
   logic irq_en_r;
   logic [7:0] osc_en_r;
   logic [TRIM_W-1:0] trim_r;
   logic [FRQ_W-1:0] frq_r;
   logic [7:0] rdata_r;
   logic fsm_r;
   logic irq_r;
   logic sleeping_r;
   logic [2:0] cfg_src;
   logic sleep_block;
   logic switching;
   logic ready_evt;
   logic do_switch;
   logic wr_req;
   csw_state_t state_r;
   csw_state_t state_nxt;

   csw_ost_if stmr ();

   csw_ost_timer #(
      .CYCLES(STARTUP_LEN)
   ) u_startup (
      .ref_clk(ref_clk),
      .reset(reset),
      .tmr(stmr.timer)
   );

   // -----------------------------------------------------------------
   // Start-up timer control.
   // -----------------------------------------------------------------

   // Restart on reset release is implicit; restart again on every wake from sleep.
   assign stmr.restart = wake_event & sleeping_r; // see [R02]
   assign stmr.bypass = external_clock_input_mode; // see [R03]

   // Fail-safe reports pass only after the start-up timer expired.
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         fsm_r <= 1'b0;
      end else begin
         fsm_r <= fail_detect & stmr.expired; // see [R01]
      end
   end

   // Sleep tracking.
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         sleeping_r <= 1'b0;
      end else if (sleep_enter) begin
         sleeping_r <= 1'b1;
      end else if (wake_event) begin
         sleeping_r <= 1'b0;
      end
   end

   // -----------------------------------------------------------------
   // Switch sequencer.
   // -----------------------------------------------------------------
   assign cfg_src = src_valid(reset_source_config) ? reset_source_config : SRC_HFI;
   assign switching = (req_src_r != cur_src_r) || (req_div_r != cur_div_r);
   // A pending switch is frozen from sleep entry until wake, so sleep runs on the old clock.
   assign sleep_block = sleep_enter || sleeping_r; // see [R21]
   assign ready_evt = (state_r == CSW_WAIT) && src_ready(req_src_r, osc_ready_in) && !sleep_block;
   // Switch takes effect when ready and not held; sleep blocks it until wake.
   assign do_switch = ((ready_evt && !hold_r) || (state_r == CSW_HELD && !hold_r)) && !sleep_block; // see [R12] [R21]
   assign wr_req = wr_en && (addr == ADDR_CLOCK_REQUEST) && switch_allow_config; // see [R07] [R17]

   // Next state of the sequencer.
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         CSW_IDLE: begin
            if (switching) begin
               state_nxt = CSW_WAIT;
            end
         end
         CSW_WAIT: begin
            if (!switching || sleep_enter || do_switch) begin
               state_nxt = CSW_IDLE; // see [R21]
            end else if (ready_evt) begin
               state_nxt = CSW_HELD;
            end
         end
         CSW_HELD: begin
            if (!switching || do_switch) begin
               state_nxt = CSW_IDLE; // see [R20]
            end
         end
         default: state_nxt = CSW_IDLE;
      endcase
   end

   // Sequencer state register.
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         state_r <= CSW_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Request register: reset from configuration, reserved source codes and over-range dividers dropped field by field.
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         req_src_r <= cfg_src; // see [R08]
         req_div_r <= reset_div(cfg_src); // see [R09]
      end else if (wr_req) begin
         if (src_valid(wdata[SRC_MSB:SRC_LSB])) begin
            req_src_r <= wdata[SRC_MSB:SRC_LSB]; // see [R06]
         end
         if (wdata[DIV_MSB:DIV_LSB] <= DIV_MAX) begin
            req_div_r <= wdata[DIV_MSB:DIV_LSB]; // see [R05]
         end
      end
   end

   // Current register: follows the request only when the switch occurs.
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         cur_src_r <= cfg_src; // see [R11]
         cur_div_r <= reset_div(cfg_src);
      end else if (do_switch) begin
         cur_src_r <= req_src_r; // see [R19]
         cur_div_r <= req_div_r;
      end
   end

   // New-ready flag: set with the ready event while held, cleared by the switch.
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         new_ready_r <= 1'b0;
      end else if (ready_evt && hold_r) begin
         new_ready_r <= 1'b1; // see [R15]
      end else if (do_switch || !switching || state_r == CSW_IDLE) begin
         new_ready_r <= 1'b0; // see [R16] [R19]
      end
   end

   // Control bits: hold and secondary power select.
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         hold_r <= 1'b0;
         spwr_r <= 1'b0;
      end else if (wr_en && addr == ADDR_SWITCH_CONTROL) begin
         hold_r <= wdata[HOLD_BIT]; // see [R12]
         spwr_r <= wdata[SPWR_BIT]; // see [R13]
      end
   end

   // Switch interrupt flag: set wins over a software clear.
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         irq_flag_r <= 1'b0;
         irq_en_r <= 1'b0;
      end else begin
         if (ready_evt) begin
            irq_flag_r <= 1'b1; // see [R18]
         end else if (wr_en && addr == ADDR_SWITCH_IRQ) begin
            irq_flag_r <= wdata[IRQ_FLAG_BIT];
         end
         if (wr_en && addr == ADDR_SWITCH_IRQ) begin
            irq_en_r <= wdata[IRQ_EN_BIT];
         end
      end
   end

   // Interrupt request output.
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= (irq_flag_r | ready_evt) & irq_en_r; // see [R18]
      end
   end

   // Manual enable, trim and frequency registers.
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         osc_en_r <= '0;
         trim_r <= '0;
         frq_r <= '0;
      end else if (wr_en) begin
         if (addr == ADDR_MANUAL_ENABLE) begin
            osc_en_r <= wdata & MANUAL_EN_MASK;
         end
         if (addr == ADDR_OSC_TRIM) begin
            trim_r <= wdata[TRIM_W-1:0];
         end
         if (addr == ADDR_OSC_FREQUENCY) begin
            frq_r <= wdata[FRQ_W-1:0];
         end
      end
   end

   // -----------------------------------------------------------------
   // Register read path.
   // -----------------------------------------------------------------

   // Read data stand one cycle after the strobe; unmapped reads return zero.
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         rdata_r <= '0;
      end else begin
         rdata_r <= '0;
         if (rd_en) begin
            case (addr)
               ADDR_CLOCK_REQUEST: rdata_r <= {1'b0, req_src_r, req_div_r};
               ADDR_CLOCK_CURRENT: rdata_r <= {1'b0, cur_src_r, cur_div_r}; // see [R10]
               ADDR_SWITCH_CONTROL: begin
                  rdata_r[HOLD_BIT] <= hold_r;
                  rdata_r[SPWR_BIT] <= spwr_r;
                  rdata_r[READY_BIT] <= !switching; // see [R14]
                  rdata_r[NRDY_BIT] <= new_ready_r;
               end
               ADDR_READY_STATUS: rdata_r <= osc_ready_in & STATUS_MASK;
               ADDR_MANUAL_ENABLE: rdata_r <= osc_en_r;
               ADDR_OSC_TRIM: rdata_r <= {2'b00, trim_r};
               ADDR_OSC_FREQUENCY: rdata_r <= {5'b00000, frq_r};
               ADDR_SWITCH_IRQ: begin
                  rdata_r[IRQ_FLAG_BIT] <= irq_flag_r;
                  rdata_r[IRQ_EN_BIT] <= irq_en_r;
               end
               default: rdata_r <= '0;
            endcase
         end
      end
   end

   // -----------------------------------------------------------------
   // Outputs.
   // -----------------------------------------------------------------
   logic [9:0] ratio_r;

   // Divide ratio one-hot from the current divider code.
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         ratio_r <= 10'h001;
      end else begin
         ratio_r <= 10'h001 << cur_div_r; // see [R05]
      end
   end

   assign rdata = rdata_r;
   assign clk_source = cur_src_r;
   assign clk_divider = cur_div_r;
   assign clk_div_ratio = ratio_r;
   assign secondary_power_select = spwr_r;
   assign osc_enable = osc_en_r;
   assign trim = trim_r;
   assign frequency = frq_r;
   assign fail_safe_monitor = fsm_r;
   assign switch_irq = irq_r;

endmodule : csw_clock_switch

// ### csw_clock_switch_chk.sv
// Concurrent checks on the ports of the clock switch control.
`timescale 1ns/1ps
module csw_clock_switch_chk
   import csw_pkg::*;
#(
   parameter int STARTUP_LEN = STARTUP_CYCLES
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic [11:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [7:0] rdata,
   input wire logic switch_allow_config,
   input wire logic external_clock_input_mode,
   input wire logic sleep_enter,
   input wire logic fail_detect,
   input wire logic [2:0] clk_source,
   input wire logic [3:0] clk_divider,
   input wire logic [9:0] clk_div_ratio,
   input wire logic secondary_power_select,
   input wire logic [5:0] trim,
   input wire logic fail_safe_monitor
);
   logic [15:0] since_rst_r;

   // Counts edges since reset release, saturating, to bound the start-up window.
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         since_rst_r <= 16'h0000;
      end else if (since_rst_r != 16'hffff) begin
         since_rst_r <= since_rst_r + 16'h0001;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   // Most tie an output to the inputs or state that cause it; div_range_a and src_legal_a only bound the codes an output holds.
   startup_gate_a: assert property (!external_clock_input_mode && since_rst_r < STARTUP_LEN |-> !fail_safe_monitor)
      else $error("fail-safe output raised inside start-up window");
   ext_bypass_a: assert property (external_clock_input_mode && since_rst_r > 16'h0002 |-> fail_safe_monitor == $past(fail_detect))
      else $error("fail-safe output not live in external clock mode");
   div_ratio_a: assert property (!$past(reset) && $stable(clk_divider) |-> clk_div_ratio == (10'h001 << clk_divider))
      else $error("division ratio does not match current divider");
   div_range_a: assert property (clk_divider <= DIV_MAX)
      else $error("current divider holds a reserved code");
   src_legal_a: assert property (clk_source != SRC_RSV3 && clk_source != SRC_RSV0)
      else $error("current source holds a reserved code");
   locked_src_a: assert property (!switch_allow_config |=> $stable(clk_source) && $stable(clk_divider))
      else $error("clock changed while switching is locked");
   sleep_cancel_a: assert property (sleep_enter |=> $stable(clk_source))
      else $error("switch completed on entry to sleep");
   rd_idle_a: assert property (!$past(rd_en) |-> rdata == 8'h00)
      else $error("read data not zero outside read answer");
   rd_current_a: assert property ($past(rd_en) && $past(addr) == ADDR_CLOCK_CURRENT |-> rdata == {1'b0, $past(clk_source), $past(clk_divider)})
      else $error("current register read differs from clock outputs");
   spwr_write_a: assert property (wr_en && addr == ADDR_SWITCH_CONTROL |=> secondary_power_select == $past(wdata[SPWR_BIT]))
      else $error("power select output not taken from write");
   trim_write_a: assert property (wr_en && addr == ADDR_OSC_TRIM |=> trim == $past(wdata[5:0]))
      else $error("trim output not taken from write");
endmodule : csw_clock_switch_chk

bind csw_clock_switch csw_clock_switch_chk #(.STARTUP_LEN(STARTUP_LEN)) u_chk (.ref_clk(ref_clk), .reset(reset), .addr(addr),
   .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .switch_allow_config(switch_allow_config),
   .external_clock_input_mode(external_clock_input_mode), .sleep_enter(sleep_enter), .fail_detect(fail_detect),
   .clk_source(clk_source), .clk_divider(clk_divider), .clk_div_ratio(clk_div_ratio),
   .secondary_power_select(secondary_power_select), .trim(trim), .fail_safe_monitor(fail_safe_monitor));

// ### csw_clock_switch_tb.sv
// Self-checking testbench for the clock switch control.
`timescale 1ns/1ps
module csw_clock_switch_tb
   import csw_pkg::*;
;
   localparam int STARTUP_T = 16;
   logic ref_clk, reset, wr_en, rd_en, switch_allow_config, external_clock_input_mode;
   logic sleep_enter, wake_event, fail_detect, secondary_power_select, fail_safe_monitor, switch_irq;
   logic [11:0] addr;
   logic [7:0] wdata, rdata, osc_ready_in, osc_enable;
   logic [2:0] reset_source_config, clk_source, frequency;
   logic [3:0] clk_divider;
   logic [9:0] clk_div_ratio;
   logic [5:0] trim;
   logic [11:0] ra [3] = '{ADDR_OSC_TRIM, ADDR_OSC_FREQUENCY, ADDR_MANUAL_ENABLE};
   logic [7:0] re [3] = '{8'h3f, 8'h07, 8'hfc};
   int err_count = 0;
   int num_checks = 0;

   csw_clock_switch #(.STARTUP_LEN(STARTUP_T)) u_dut (.ref_clk(ref_clk), .reset(reset), .addr(addr), .wdata(wdata),
      .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .reset_source_config(reset_source_config),
      .switch_allow_config(switch_allow_config), .external_clock_input_mode(external_clock_input_mode),
      .sleep_enter(sleep_enter), .wake_event(wake_event), .osc_ready_in(osc_ready_in), .fail_detect(fail_detect),
      .clk_source(clk_source), .clk_divider(clk_divider), .clk_div_ratio(clk_div_ratio),
      .secondary_power_select(secondary_power_select), .osc_enable(osc_enable), .trim(trim),
      .frequency(frequency), .fail_safe_monitor(fail_safe_monitor), .switch_irq(switch_irq));

   // Free-running 50 MHz clock.
   always #10 ref_clk = ~ref_clk;

   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   // Compares a seen value with the expected one and counts the result.
   task automatic chk(input string nm, input logic [9:0] seen, input logic [9:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   // Lets n rising edges pass and settles just after the last one.
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : cyc

   // One-cycle write strobe on the register port.
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge ref_clk);
      wr_en <= 1'b0;
      #1;
   endtask : wr

   // One-cycle read strobe; the answer is looked at in the following cycle only.
   task automatic rd(input logic [11:0] a, input logic [7:0] e);
      @(posedge ref_clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge ref_clk);
      rd_en <= 1'b0;
      #1;
      chk("rdata", {2'b00, rdata}, {2'b00, e});
   endtask : rd

   // Waits a bounded time for the current source to reach a value.
   task automatic wait_src(input logic [2:0] s);
      for (int i = 0; i < 20 && clk_source !== s; i++) cyc(1);
      chk("clk_source", {7'h00, clk_source}, {7'h00, s});
   endtask : wait_src

   // Raises reset for five edges and releases it on an edge.
   task automatic do_reset;
      @(posedge ref_clk);
      reset <= 1'b1;
      repeat (5) @(posedge ref_clk);
      reset <= 1'b0;
      #1;
   endtask : do_reset

   // Prints the counts and the verdict, then ends the run.
   task automatic test_done;
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : test_done

   // Cuts a hung run short.
   initial begin
      repeat (5000) @(posedge ref_clk);
      err_count++;
      test_done();
   end

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      ref_clk = 1'b0;
      reset = 1'b1;
      addr = 12'h000;
      wdata = 8'h00;
      wr_en = 1'b0;
      rd_en = 1'b0;
      reset_source_config = SRC_HFI;
      switch_allow_config = 1'b1;
      external_clock_input_mode = 1'b0;
      sleep_enter = 1'b0;
      wake_event = 1'b0;
      osc_ready_in = 8'hff;
      fail_detect = 1'b1;
      do_reset;
      cyc(STARTUP_T / 2);
      chk("fail_safe", 10'(fail_safe_monitor), 10'h000);
      cyc(2 * STARTUP_T);
      chk("fail_safe", 10'(fail_safe_monitor), 10'h001);
      @(posedge ref_clk);
      fail_detect <= 1'b0;
      rd(ADDR_CLOCK_REQUEST, 8'h62);
      rd(ADDR_CLOCK_CURRENT, 8'h62);
      rd(ADDR_SWITCH_CONTROL, 8'h10);
      chk("div_ratio", clk_div_ratio, 10'h004);
      rd(12'h88c, 8'h00);
      rd(12'h895, 8'h00);
      foreach (ra[i]) begin
         wr(ra[i], 8'hff);
         rd(ra[i], re[i]);
      end
      chk("trim", 10'(trim), 10'h03f);
      chk("frequency", 10'(frequency), 10'h007);
      chk("osc_enable", 10'(osc_enable), 10'h0fc);
      // Immediate switch to the largest divider.
      wr(ADDR_CLOCK_REQUEST, 8'h59);
      wait_src(SRC_LFI);
      chk("clk_divider", 10'(clk_divider), 10'h009);
      cyc(2);
      chk("div_ratio", clk_div_ratio, 10'h200);
      rd(ADDR_CLOCK_CURRENT, 8'h59);
      rd(ADDR_SWITCH_CONTROL, 8'h10);
      rd(ADDR_SWITCH_IRQ, 8'h01);
      wr(ADDR_SWITCH_IRQ, 8'h00);
      // Reserved source codes and an over-range divider are refused.
      wr(ADDR_CLOCK_REQUEST, 8'h39);
      wr(ADDR_CLOCK_REQUEST, 8'h09);
      wr(ADDR_CLOCK_REQUEST, 8'h5a);
      rd(ADDR_CLOCK_REQUEST, 8'h59);
      // Held switch, interrupt flag and release.
      @(posedge ref_clk);
      osc_ready_in <= 8'h7f;
      wr(ADDR_SWITCH_CONTROL, 8'h80);
      wr(ADDR_CLOCK_REQUEST, 8'h70);
      cyc(5);
      rd(ADDR_SWITCH_CONTROL, 8'h80);
      @(posedge ref_clk);
      osc_ready_in <= 8'hff;
      cyc(5);
      rd(ADDR_SWITCH_CONTROL, 8'h88);
      chk("clk_source", 10'(clk_source), 10'(SRC_LFI));
      rd(ADDR_SWITCH_IRQ, 8'h01);
      chk("switch_irq", 10'(switch_irq), 10'h000);
      wr(ADDR_SWITCH_IRQ, 8'h03);
      cyc(2);
      chk("switch_irq", 10'(switch_irq), 10'h001);
      wr(ADDR_SWITCH_CONTROL, 8'h00);
      wait_src(SRC_EXT);
      rd(ADDR_SWITCH_CONTROL, 8'h10);
      wr(ADDR_SWITCH_IRQ, 8'h02);
      cyc(2);
      chk("switch_irq", 10'(switch_irq), 10'h000);
      // Held switch abandoned by copying the current source back.
      wr(ADDR_SWITCH_CONTROL, 8'hc0);
      chk("power_select", 10'(secondary_power_select), 10'h001);
      wr(ADDR_CLOCK_REQUEST, 8'h40);
      cyc(5);
      rd(ADDR_SWITCH_CONTROL, 8'hc8);
      wr(ADDR_CLOCK_REQUEST, 8'h70);
      cyc(3);
      rd(ADDR_SWITCH_CONTROL, 8'hd0);
      chk("clk_source", 10'(clk_source), 10'(SRC_EXT));
      wr(ADDR_SWITCH_CONTROL, 8'h00);
      // Sleep in the cycle the new source turns ready defers the switch until wake.
      @(posedge ref_clk);
      osc_ready_in <= 8'hef;
      wr(ADDR_CLOCK_REQUEST, 8'h50);
      cyc(4);
      @(posedge ref_clk);
      osc_ready_in <= 8'hff;
      sleep_enter <= 1'b1;
      @(posedge ref_clk);
      sleep_enter <= 1'b0;
      #1;
      chk("clk_source", 10'(clk_source), 10'(SRC_EXT));
      cyc(3);
      chk("clk_source", 10'(clk_source), 10'(SRC_EXT));
      @(posedge ref_clk);
      wake_event <= 1'b1;
      @(posedge ref_clk);
      wake_event <= 1'b0;
      wait_src(SRC_LFI);
      // Locked request register, other reset source, external clock mode.
      @(posedge ref_clk);
      reset_source_config <= SRC_LFI;
      switch_allow_config <= 1'b0;
      external_clock_input_mode <= 1'b1;
      fail_detect <= 1'b1;
      do_reset;
      cyc(4);
      chk("fail_safe", 10'(fail_safe_monitor), 10'h001);
      rd(ADDR_CLOCK_REQUEST, 8'h50);
      wr(ADDR_CLOCK_REQUEST, 8'h62);
      rd(ADDR_CLOCK_REQUEST, 8'h50);
      rd(ADDR_CLOCK_CURRENT, 8'h50);
      test_done();
   end
endmodule : csw_clock_switch_tb
